// >>> src/burst_sram_regs.vh
// constants for the pipelined burst sram port and its avalon register window
`ifndef BURST_SRAM_REGS_VH
`define BURST_SRAM_REGS_VH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define LANE_WIDTH          9
`define LANE_COUNT          2
`define UPPER_ADDR_WIDTH    17
`define BURST_BITS          2

// ----------------------------------------------------------------
// avalon register byte offsets
// ----------------------------------------------------------------
`define REG_CTRL_OFFSET     5'h00
`define REG_STATUS_OFFSET   5'h04
`define REG_ADDR_OFFSET     5'h08
`define REG_READS_OFFSET    5'h0c
`define REG_WRITES_OFFSET   5'h10
`define REG_WAITS_OFFSET    5'h14

// ----------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------
`define CTRL_PORT_ENABLE_BIT   0
`define CTRL_CLEAR_COUNT_BIT   1
`define CTRL_RESET_VALUE       8'h01
`define STATUS_SELECTED_BIT    0
`define STATUS_WRITING_BIT     1
`define STATUS_INTERLEAVE_BIT  2
`define STATUS_COUNT_LSB       4

`endif

// >>> src/burst_sequencer.v
// two-bit burst counter producing the low address bits in linear or interleaved order
`timescale 1ns/1ps
module burst_sequencer (
    input  wire       clock_in,
    input  wire       resetn_in,
    input  wire       load_in,
    input  wire [1:0] start_bits_in,
    input  wire       step_in,
    input  wire       interleave_in,
    output wire [1:0] low_bits_out,
    output wire [1:0] count_out
);

    reg [1:0] start_reg;
    reg [1:0] count_reg;

    // ------------------------------------------------------------
    // order function
    // ------------------------------------------------------------
    // wraps inside four addresses either way, no carry into upper bits
    function [1:0] order_bits;
        input [1:0] start;
        input [1:0] count;
        input       interleave;
        begin
            if (interleave) begin
                order_bits = start ^ count;
            end else begin
                order_bits = start + count;
            end
        end
    endfunction

    // counter loads on a new address, steps on burst advance, holds otherwise
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            start_reg <= 2'h0;
            count_reg <= 2'h0;
        end else if (load_in) begin
            start_reg <= start_bits_in;
            count_reg <= 2'h0;
        end else if (step_in) begin
            count_reg <= count_reg + 2'h1;
        end
    end

    assign low_bits_out = order_bits(start_reg, count_reg, interleave_in);
    assign count_out    = count_reg;

endmodule

// >>> src/byte_lane_memory.v
// byte-lane organised storage array with per-lane writes and a registered read port
`timescale 1ns/1ps
module byte_lane_memory #(
    parameter ADDR_WIDTH = 19,
    parameter LANE_WIDTH = 9,
    parameter LANES      = 2
) (
    input  wire                        clock_in,
    input  wire [ADDR_WIDTH-1:0]       addr_in,
    input  wire [LANES-1:0]            lane_write_in,
    input  wire [LANES*LANE_WIDTH-1:0] wdata_in,
    input  wire                        read_in,
    output wire [LANES*LANE_WIDTH-1:0] rdata_out
);

    genvar lane;

    // each lane is its own array so a lane write never disturbs a neighbour
    generate
        for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane
            reg [LANE_WIDTH-1:0] store [0:(1<<ADDR_WIDTH)-1];
            reg [LANE_WIDTH-1:0] rdata_reg;

            // lane index 0 is the first lane, index 1 the second
            always @(posedge clock_in) begin
                if (lane_write_in[lane]) begin
                    store[addr_in] <= wdata_in[lane*LANE_WIDTH +: LANE_WIDTH];
                end
                if (read_in) begin
                    rdata_reg <= store[addr_in];
                end
            end

            assign rdata_out[lane*LANE_WIDTH +: LANE_WIDTH] = rdata_reg;
        end
    endgenerate

endmodule

// >>> src/burst_sram_port.v
// pipelined burst sram port: pin registers, cycle decode, burst addressing, avalon window
`timescale 1ns/1ps
`include "burst_sram_regs.vh"
module burst_sram_port #(
    parameter UPPER_WIDTH = `UPPER_ADDR_WIDTH,
    parameter LANE_WIDTH  = `LANE_WIDTH
) (
    input  wire                   CLOCK_IN,
    input  wire                   RESETN_IN,
    // sram pins
    input  wire [UPPER_WIDTH-1:0] ADDR_IN,
    input  wire                   BURST_ADDR_BIT_LOW_IN,
    input  wire                   BURST_ADDR_BIT_HIGH_IN,
    input  wire [LANE_WIDTH-1:0]  DATA_LANE_FIRST_IN,
    input  wire [LANE_WIDTH-1:0]  DATA_LANE_SECOND_IN,
    output wire [LANE_WIDTH-1:0]  DATA_LANE_FIRST_OUT,
    output wire [LANE_WIDTH-1:0]  DATA_LANE_SECOND_OUT,
    output wire                   DATA_LANE_OE_OUT,
    input  wire                   CHIP_ENABLE_N_IN,
    input  wire                   CHIP_ENABLE_HIGH_IN,
    input  wire                   PROCESSOR_ADDR_STROBE_N_IN,
    input  wire                   CONTROLLER_ADDR_STROBE_N_IN,
    input  wire                   BURST_STEP_N_IN,
    input  wire                   LANE_FIRST_WRITE_STROBE_N_IN,
    input  wire                   LANE_SECOND_WRITE_STROBE_N_IN,
    input  wire                   BYTE_WRITE_GATE_N_IN,
    input  wire                   GLOBAL_WRITE_N_IN,
    input  wire                   SEQUENCE_SELECT_IN,
    // avalon-mm slave
    input  wire [4:0]             AVS_ADDRESS_IN,
    input  wire                   AVS_READ_IN,
    input  wire                   AVS_WRITE_IN,
    input  wire [31:0]            AVS_WRITEDATA_IN,
    input  wire [3:0]             AVS_BYTEENABLE_IN,
    output wire [31:0]            AVS_READDATA_OUT,
    output wire                   AVS_WAITREQUEST_OUT
);

    localparam ADDR_WIDTH = UPPER_WIDTH + `BURST_BITS;
    localparam DATA_WIDTH = `LANE_COUNT * LANE_WIDTH;
    localparam [7:0] CTRL_RESET = `CTRL_RESET_VALUE;

    // one-hot cycle kinds of the access stage
    localparam [2:0] ST_DESELECT = 3'b001;
    localparam [2:0] ST_READ     = 3'b010;
    localparam [2:0] ST_WRITE    = 3'b100;

    // ------------------------------------------------------------
    // pin input registers
    // ------------------------------------------------------------
    reg [UPPER_WIDTH-1:0] addr_q_reg;
    reg [1:0]             low_q_reg;
    reg [DATA_WIDTH-1:0]  data_q_reg;
    reg                   ce_n_q_reg;
    reg                   ce_high_q_reg;
    reg                   proc_strobe_n_q_reg;
    reg                   ctrl_strobe_n_q_reg;
    reg                   step_n_q_reg;
    reg [1:0]             lane_strobe_n_q_reg;
    reg                   gate_n_q_reg;
    reg                   global_n_q_reg;
    reg                   interleave_q_reg;

    // every synchronous pin is caught on the same rising edge
    always @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            addr_q_reg          <= {UPPER_WIDTH{1'b0}};
            low_q_reg           <= 2'h0;
            data_q_reg          <= {DATA_WIDTH{1'b0}};
            ce_n_q_reg          <= 1'b1;
            ce_high_q_reg       <= 1'b0;
            proc_strobe_n_q_reg <= 1'b1;
            ctrl_strobe_n_q_reg <= 1'b1;
            step_n_q_reg        <= 1'b1;
            lane_strobe_n_q_reg <= 2'h3;
            gate_n_q_reg        <= 1'b1;
            global_n_q_reg      <= 1'b1;
            interleave_q_reg    <= 1'b1;
        end else begin
            addr_q_reg          <= ADDR_IN;
            low_q_reg           <= {BURST_ADDR_BIT_HIGH_IN, BURST_ADDR_BIT_LOW_IN};
            data_q_reg          <= {DATA_LANE_SECOND_IN, DATA_LANE_FIRST_IN};
            ce_n_q_reg          <= CHIP_ENABLE_N_IN;
            ce_high_q_reg       <= CHIP_ENABLE_HIGH_IN;
            proc_strobe_n_q_reg <= PROCESSOR_ADDR_STROBE_N_IN;
            ctrl_strobe_n_q_reg <= CONTROLLER_ADDR_STROBE_N_IN;
            step_n_q_reg        <= BURST_STEP_N_IN;
            lane_strobe_n_q_reg <= {LANE_SECOND_WRITE_STROBE_N_IN,
                                    LANE_FIRST_WRITE_STROBE_N_IN};
            gate_n_q_reg        <= BYTE_WRITE_GATE_N_IN;
            global_n_q_reg      <= GLOBAL_WRITE_N_IN;
            interleave_q_reg    <= SEQUENCE_SELECT_IN;
        end
    end

    // ------------------------------------------------------------
    // software control state
    // ------------------------------------------------------------
    reg  port_enable_reg;
    wire clear_count_pulse;

    // ------------------------------------------------------------
    // cycle decode on the registered pins
    // ------------------------------------------------------------
    reg                   selected_reg;
    reg [1:0]             lane_write;
    wire                  start_proc;
    wire                  start_ctrl;
    wire                  ctrl_selects;
    wire                  continue_burst;
    wire                  any_write;
    wire                  write_cycle;
    wire                  read_cycle;
    reg [2:0]             kind_next;

    // lane enables: global write forces both, else strobes only behind the gate
    always @* begin
        if (!global_n_q_reg) begin
            lane_write = 2'h3;
        end else if (!gate_n_q_reg) begin
            lane_write = ~lane_strobe_n_q_reg;
        end else begin
            lane_write = 2'h0;
        end
    end

    // processor strobe counts only with chip enable low and software enable
    assign start_proc     = port_enable_reg & ~proc_strobe_n_q_reg & ~ce_n_q_reg;
    // controller strobe is honoured with software enable whenever the processor one is not
    assign start_ctrl     = port_enable_reg & ~ctrl_strobe_n_q_reg & ~start_proc;
    assign ctrl_selects   = ~ce_n_q_reg & ce_high_q_reg;
    assign continue_burst = selected_reg & ~start_proc & ~start_ctrl;
    assign any_write      = |lane_write;
    // a processor strobe cycle is always a read, write controls apply afterwards
    assign write_cycle    = any_write & ((start_ctrl & ctrl_selects) | continue_burst);
    assign read_cycle     = start_proc | (~any_write & ((start_ctrl & ctrl_selects)
                                                        | continue_burst));

    // one-hot classification of the coming access
    always @* begin
        case (1'b1)
            write_cycle: kind_next = ST_WRITE;
            read_cycle:  kind_next = ST_READ;
            default:     kind_next = ST_DESELECT;
        endcase
    end

    // selection follows the strobes; a burst keeps it until the next strobe
    always @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            selected_reg <= 1'b0;
        end else if (start_proc) begin
            selected_reg <= 1'b1;
        end else if (start_ctrl) begin
            selected_reg <= ctrl_selects;
        end
    end

    // ------------------------------------------------------------
    // address register and burst counter
    // ------------------------------------------------------------
    reg  [UPPER_WIDTH-1:0] upper_reg;
    wire [1:0]             burst_low;
    wire [1:0]             burst_count;
    wire                   load_addr;
    wire                   step_burst;

    assign load_addr  = start_proc | start_ctrl;
    assign step_burst = continue_burst & ~step_n_q_reg;

    // upper bits come only from the pins, the counter never carries into them
    always @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            upper_reg <= {UPPER_WIDTH{1'b0}};
        end else if (load_addr) begin
            upper_reg <= addr_q_reg;
        end
    end

    burst_sequencer u_sequencer (
        .clock_in      (CLOCK_IN),
        .resetn_in     (RESETN_IN),
        .load_in       (load_addr),
        .start_bits_in (low_q_reg),
        .step_in       (step_burst),
        .interleave_in (interleave_q_reg),
        .low_bits_out  (burst_low),
        .count_out     (burst_count)
    );

    // ------------------------------------------------------------
    // access stage
    // ------------------------------------------------------------
    reg [2:0]            kind_reg;
    reg [1:0]            lane_write_reg;
    reg [DATA_WIDTH-1:0] wdata_reg;
    reg                  oe_reg;
    wire [ADDR_WIDTH-1:0] access_addr;
    wire [1:0]            mem_write;
    wire [DATA_WIDTH-1:0] rdata;
    wire                  write_hold;

    // the data and controls sampled together travel as one access
    always @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            kind_reg       <= ST_DESELECT;
            lane_write_reg <= 2'h0;
            wdata_reg      <= {DATA_WIDTH{1'b0}};
        end else begin
            kind_reg       <= kind_next;
            lane_write_reg <= lane_write;
            wdata_reg      <= data_q_reg;
        end
    end

    // low bits always come from the counter once the address is loaded
    assign access_addr = {upper_reg, burst_low};
    assign mem_write   = (kind_reg == ST_WRITE) ? lane_write_reg : 2'h0;

    byte_lane_memory #(
        .ADDR_WIDTH (ADDR_WIDTH),
        .LANE_WIDTH (LANE_WIDTH),
        .LANES      (`LANE_COUNT)
    ) u_memory (
        .clock_in      (CLOCK_IN),
        .addr_in       (access_addr),
        .lane_write_in (mem_write),
        .wdata_in      (wdata_reg),
        .read_in       (kind_reg == ST_READ),
        .rdata_out     (rdata)
    );

    // drivers turn on one cycle after a read access, matching the read pipeline
    always @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= (kind_reg == ST_READ);
        end
    end

    // a gated lane strobe or global write seen on the pins releases the bus at once,
    // so the controller can drive write data without contention
    assign write_hold = (~gate_n_q_reg & ~(&lane_strobe_n_q_reg)) | ~global_n_q_reg;
    assign DATA_LANE_OE_OUT     = oe_reg & ~write_hold;
    assign DATA_LANE_FIRST_OUT  = rdata[LANE_WIDTH-1:0];
    assign DATA_LANE_SECOND_OUT = rdata[DATA_WIDTH-1:LANE_WIDTH];

    // ------------------------------------------------------------
    // activity counters
    // ------------------------------------------------------------
    reg [31:0] reads_reg;
    reg [31:0] writes_reg;
    reg [31:0] waits_reg;
    wire       wait_cycle;

    assign wait_cycle = continue_burst & step_n_q_reg;

    // an event in the clearing cycle counts as the first after the clear
    always @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            reads_reg  <= 32'h0;
            writes_reg <= 32'h0;
            waits_reg  <= 32'h0;
        end else if (clear_count_pulse) begin
            reads_reg  <= {31'h0, read_cycle};
            writes_reg <= {31'h0, write_cycle};
            waits_reg  <= {31'h0, wait_cycle};
        end else begin
            reads_reg  <= reads_reg + {31'h0, read_cycle};
            writes_reg <= writes_reg + {31'h0, write_cycle};
            waits_reg  <= waits_reg + {31'h0, wait_cycle};
        end
    end

    // ------------------------------------------------------------
    // avalon-mm slave
    // ------------------------------------------------------------
    reg        ack_reg;
    reg [31:0] readdata_reg;
    reg [31:0] read_mux;
    wire       request;
    wire       write_commit;

    // decodes a byte address into its register word, used for reads and writes
    function [2:0] reg_index;
        input [4:0] addr;
        begin
            case (addr & 5'h1c)
                `REG_CTRL_OFFSET:   reg_index = 3'h0;
                `REG_STATUS_OFFSET: reg_index = 3'h1;
                `REG_ADDR_OFFSET:   reg_index = 3'h2;
                `REG_READS_OFFSET:  reg_index = 3'h3;
                `REG_WRITES_OFFSET: reg_index = 3'h4;
                `REG_WAITS_OFFSET:  reg_index = 3'h5;
                default:            reg_index = 3'h7;
            endcase
        end
    endfunction

    // every request waits exactly one cycle; fixed latency keeps the slave trivial
    assign request             = AVS_READ_IN | AVS_WRITE_IN;
    assign AVS_WAITREQUEST_OUT = request & ~ack_reg;
    assign write_commit        = AVS_WRITE_IN & ack_reg;
    assign AVS_READDATA_OUT    = readdata_reg;
    assign clear_count_pulse   = write_commit & AVS_BYTEENABLE_IN[0]
                                 & (reg_index(AVS_ADDRESS_IN) == 3'h0)
                                 & AVS_WRITEDATA_IN[`CTRL_CLEAR_COUNT_BIT];

    // read mux; unmapped words and reserved bits read as zero
    always @* begin
        read_mux = 32'h0;
        case (reg_index(AVS_ADDRESS_IN))
            3'h0: read_mux[`CTRL_PORT_ENABLE_BIT] = port_enable_reg;
            3'h1: begin
                read_mux[`STATUS_SELECTED_BIT]   = selected_reg;
                read_mux[`STATUS_WRITING_BIT]    = (kind_reg == ST_WRITE);
                read_mux[`STATUS_INTERLEAVE_BIT] = interleave_q_reg;
                read_mux[`STATUS_COUNT_LSB +: 2] = burst_count;
            end
            3'h2: read_mux[ADDR_WIDTH-1:0] = access_addr;
            3'h3: read_mux = reads_reg;
            3'h4: read_mux = writes_reg;
            3'h5: read_mux = waits_reg;
            default: read_mux = 32'h0;
        endcase
    end

    // handshake and read data capture
    always @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            ack_reg      <= 1'b0;
            readdata_reg <= 32'h0;
        end else begin
            ack_reg <= request & ~ack_reg;
            if (AVS_READ_IN & ~ack_reg) begin
                readdata_reg <= read_mux;
            end
        end
    end

    // port enable lives in byte lane 0; the clear bit is a write-only pulse
    always @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            port_enable_reg <= CTRL_RESET[`CTRL_PORT_ENABLE_BIT];
        end else if (write_commit & AVS_BYTEENABLE_IN[0]
                     & (reg_index(AVS_ADDRESS_IN) == 3'h0)) begin
            port_enable_reg <= AVS_WRITEDATA_IN[`CTRL_PORT_ENABLE_BIT];
        end
    end

endmodule

// >>> testbench/burst_sram_port_assertions.sv
// pin-level and avalon handshake checks bound to the burst sram port
`timescale 1ns/1ps
module burst_sram_checker #(
    parameter W = 9
) (
    input wire logic         CLOCK_IN,
    input wire logic         RESETN_IN,
    input wire logic         CHIP_ENABLE_N_IN,
    input wire logic         CHIP_ENABLE_HIGH_IN,
    input wire logic         PROCESSOR_ADDR_STROBE_N_IN,
    input wire logic         CONTROLLER_ADDR_STROBE_N_IN,
    input wire logic         BURST_STEP_N_IN,
    input wire logic         LANE_FIRST_WRITE_STROBE_N_IN,
    input wire logic         LANE_SECOND_WRITE_STROBE_N_IN,
    input wire logic         BYTE_WRITE_GATE_N_IN,
    input wire logic         GLOBAL_WRITE_N_IN,
    input wire logic [W-1:0] DATA_LANE_FIRST_OUT,
    input wire logic [W-1:0] DATA_LANE_SECOND_OUT,
    input wire logic         DATA_LANE_OE_OUT,
    input wire logic         AVS_READ_IN,
    input wire logic         AVS_WRITE_IN,
    input wire logic         AVS_WAITREQUEST_OUT
);
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RESETN_IN);
    // ---------------------
    // decoded pin states
    // ---------------------
    wire ps       = !PROCESSOR_ADDR_STROBE_N_IN;
    wire cs       = !CONTROLLER_ADDR_STROBE_N_IN;
    wire step     = !BURST_STEP_N_IN;
    wire oe       = DATA_LANE_OE_OUT;
    wire lanes_hi = LANE_FIRST_WRITE_STROBE_N_IN && LANE_SECOND_WRITE_STROBE_N_IN;
    wire no_wr    = GLOBAL_WRITE_N_IN && (BYTE_WRITE_GATE_N_IN || lanes_hi);
    wire quiet    = !ps && !cs && no_wr;
    wire ps_rd    = ps && !CHIP_ENABLE_N_IN;
    wire cs_rd    = !ps && cs && !CHIP_ENABLE_N_IN && CHIP_ENABLE_HIGH_IN && no_wr;
    wire desel    = !ps && cs && CHIP_ENABLE_N_IN;
    wire ps_ign   = ps && !cs && CHIP_ENABLE_N_IN;
    wire req      = AVS_READ_IN || AVS_WRITE_IN;
    gated_lane_off_a: assert property (!BYTE_WRITE_GATE_N_IN && !lanes_hi |=> !oe)
        else $error("lanes on in byte write");
    global_write_off_a: assert property (!GLOBAL_WRITE_N_IN |=> !oe)
        else $error("lanes on in global write");
    proc_read_oe_a: assert property (ps_rd ##2 no_wr |=> oe)
        else $error("no data after processor read");
    ctrl_read_oe_a: assert property (cs_rd ##2 no_wr |=> oe)
        else $error("no data after controller read");
    ignored_strobe_a: assert property (desel ##1 ps_ign |-> ##2 !oe ##1 !oe)
        else $error("deselected lanes driven");
    wait_hold_a: assert property (quiet && step ##1 quiet && !step
        |-> ##3 $stable(DATA_LANE_FIRST_OUT) && $stable(DATA_LANE_SECOND_OUT))
        else $error("wait moved data");
    ack_second_a: assert property (req && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
        else $error("waitrequest too long");
    wait_first_a: assert property (req && !$past(req) |-> AVS_WAITREQUEST_OUT)
        else $error("answered in first cycle");
    read_seen_c: cover property (ps_rd ##3 oe);
    wait_seen_c: cover property (quiet && !step);
    write_seen_c: cover property (!GLOBAL_WRITE_N_IN);
endmodule
bind burst_sram_port burst_sram_checker #(.W(LANE_WIDTH)) u_checker (.*);

// >>> testbench/cache_ctrl_model.sv
// cache controller model that drives the sram pins one beat per clock
`timescale 1ns/1ps
module cache_ctrl_model (
    input  wire logic   clk_in,
    output logic [16:0] addr_out,
    output logic        a0_out,
    output logic        a1_out,
    output logic [8:0]  d1_out,
    output logic [8:0]  d2_out,
    output logic        ce_n_out,
    output logic        ps_n_out,
    output logic        cs_n_out,
    output logic        adv_n_out,
    output logic        w1_n_out,
    output logic        w2_n_out,
    output logic        gate_n_out,
    output logic        gw_n_out
);
    // idle pins: no strobe, no write, not selected
    initial {ce_n_out, ps_n_out, cs_n_out, adv_n_out, w1_n_out, w2_n_out, gate_n_out, gw_n_out} = 8'hff;
    initial {addr_out, a1_out, a0_out, d2_out, d1_out} = 37'h0;
    // pins change just after the edge and stand the whole cycle
    task beat(input logic ps, cs, ce, burst_step_n, gate, input logic [1:0] ln,
              input logic gw, input logic [18:0] a, input logic [17:0] d);
        @(posedge clk_in);
        {ps_n_out, cs_n_out, ce_n_out, adv_n_out, gate_n_out} <= {ps, cs, ce, burst_step_n, gate};
        {w2_n_out, w1_n_out, gw_n_out} <= {ln, gw};
        {addr_out, a1_out, a0_out} <= a;
        // beats without a write carry flipped junk on both lanes
        {d2_out, d1_out} <= (!gw || (!gate && ln != 2'h3)) ? d : ~{d2_out, d1_out};
    endtask
endmodule

// >>> testbench/pipelined_burst_sram_port_bench.sv
// self-checking bench: sram write and read bursts plus the avalon window
`timescale 1ns/1ps
module pipelined_burst_sram_port_bench;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        seq = 1'b0;
    logic        avs_rd = 1'b0;
    logic        avs_wr = 1'b0;
    logic [4:0]  avs_ad = 5'h00;
    logic [31:0] avs_wd = 32'h0;
    logic [31:0] r;
    logic [16:0] base;
    logic [17:0] mem [4];
    logic [17:0] exp_q [$];
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          m;
    wire  [31:0] avs_q;
    wire  [16:0] addr;
    wire  [8:0]  d1, d2, q1, q2;
    wire         a0, a1, ce_n, ps_n, cs_n, adv_n, w1_n, w2_n, gate_n, gw_n, oe, wreq;
    always #50 clock = ~clock;
    cache_ctrl_model u_cache_ctrl_model (.clk_in(clock), .addr_out(addr), .a0_out(a0),
        .a1_out(a1), .d1_out(d1), .d2_out(d2), .ce_n_out(ce_n), .ps_n_out(ps_n),
        .cs_n_out(cs_n), .adv_n_out(adv_n), .w1_n_out(w1_n), .w2_n_out(w2_n),
        .gate_n_out(gate_n), .gw_n_out(gw_n));
    burst_sram_port u_burst_sram_port (.CLOCK_IN(clock), .RESETN_IN(resetn), .ADDR_IN(addr),
        .BURST_ADDR_BIT_LOW_IN(a0), .BURST_ADDR_BIT_HIGH_IN(a1), .DATA_LANE_FIRST_IN(d1),
        .DATA_LANE_SECOND_IN(d2), .DATA_LANE_FIRST_OUT(q1), .DATA_LANE_SECOND_OUT(q2),
        .DATA_LANE_OE_OUT(oe), .CHIP_ENABLE_N_IN(ce_n), .CHIP_ENABLE_HIGH_IN(1'b1),
        .PROCESSOR_ADDR_STROBE_N_IN(ps_n), .CONTROLLER_ADDR_STROBE_N_IN(cs_n),
        .BURST_STEP_N_IN(adv_n), .LANE_FIRST_WRITE_STROBE_N_IN(w1_n),
        .LANE_SECOND_WRITE_STROBE_N_IN(w2_n), .BYTE_WRITE_GATE_N_IN(gate_n),
        .GLOBAL_WRITE_N_IN(gw_n), .SEQUENCE_SELECT_IN(seq), .AVS_ADDRESS_IN(avs_ad),
        .AVS_READ_IN(avs_rd), .AVS_WRITE_IN(avs_wr), .AVS_WRITEDATA_IN(avs_wd),
        .AVS_BYTEENABLE_IN(4'hf), .AVS_READDATA_OUT(avs_q), .AVS_WAITREQUEST_OUT(wreq));
    task chk(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask
    task results;
        $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // avalon master: request holds until waitrequest is low at a rising edge
    task automatic av(input logic wr, input logic [4:0] ad, input logic [31:0] wd);
        int n = 0;
        @(posedge clock);
        {avs_rd, avs_wr, avs_ad, avs_wd} <= {!wr, wr, ad, wd};
        do begin
            @(posedge clock);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        r = avs_q;
        {avs_rd, avs_wr} <= 2'b00;
        if (n >= 20) chk(32'h1, 32'h0);
    endtask
    function automatic logic [1:0] ord(input logic [1:0] s, c);
        return seq ? s ^ c : s + c;
    endfunction
    // deselect, then a processor strobe that must be ignored
    task desel(input logic [1:0] s);
        u_cache_ctrl_model.beat(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 2'h3, 1'b1, {base, s}, 18'h0);
        u_cache_ctrl_model.beat(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, 1'b1, {base, s}, 18'h0);
    endtask
    // four writes, a wrapping read step, deselect
    task automatic wr_burst(input logic g);
        logic [1:0] s, ln, ix;
        logic [17:0] d;
        s = 2'($urandom);
        for (int i = 0; i < 4; i++) begin
            d = 18'($urandom);
            ln = g ? 2'h3 : 2'($urandom % 3);
            ix = ord(s, i[1:0]);
            if (g || !ln[0]) mem[ix][8:0] = d[8:0];
            if (g || !ln[1]) mem[ix][17:9] = d[17:9];
            u_cache_ctrl_model.beat(1'b1, i != 0, 1'b0, i == 0, g, ln, !g, {base, s}, d);
        end
        exp_q.push_back(mem[s]);
        u_cache_ctrl_model.beat(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 1'b1, {base, s}, 18'h0);
        desel(s);
    endtask
    // read burst, wait after first step
    task automatic rd_burst(input logic p);
        logic [1:0] s;
        s = 2'($urandom);
        for (int i = 0; i < 5; i++) begin
            exp_q.push_back(mem[ord(s, 2'(i - (i > 1)))]);
            u_cache_ctrl_model.beat(!(p && i == 0), !(!p && i == 0), 1'b0, i == 0 || i == 2,
                                    1'b1, 2'h3, 1'b1, {base, s}, 18'h0);
        end
        desel(s);
    endtask
    // each driven beat pops the oldest expected word
    always @(negedge clock) if (oe === 1'b1) begin
        if (exp_q.size() == 0) chk(32'h1, 32'h0);
        else chk({q2, q1}, exp_q.pop_front());
    end
    // watchdog far past the run's length
    initial begin
        #2000000;
        n_mismatch++;
        results();
    end
    initial begin
        void'($urandom(47));
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        av(1'b0, 5'h00, 32'h0);
        chk(r, 32'h1);
        base = 17'($urandom);
        for (m = 0; m < 2; m++) begin
            @(posedge clock);
            seq <= m[0];
            @(posedge clock);
            wr_burst(1'b1);
            wr_burst(1'b0);
            rd_burst(1'b1);
            rd_burst(1'b0);
            av(1'b0, 5'h04, 32'h0);
            chk(32'(r[2]), 32'(seq));
            $display("test burst order %0d done", m);
        end
        av(1'b1, 5'h00, 32'h3);
        av(1'b0, 5'h10, 32'h0);
        chk(r, 32'h0);
        av(1'b0, 5'h00, 32'h0);
        chk(r, 32'h1);
        av(1'b1, 5'h18, 32'hffffffff);
        av(1'b0, 5'h18, 32'h0);
        chk(r, 32'h0);
        $display("test registers done");
        repeat (4) @(posedge clock);
        chk(32'(exp_q.size()), 32'h0);
        results();
    end
endmodule
